// >>> hdl/regulator_irq_mask_gating.sv
// What this block does
// R1 - sd1 valid mask bit 6 gates pg flag
// R2 - sd1 live power-good ignores every mask
// R3 - sd1 mask bit 4 gates current-limit flag
// R4 - sd1 live current-limit ignores the mask
// R5 - sd0 mask bit 3 gates pg-invalid flag
// R6 - sd0 mask bit 2 gates pg-valid flag
// R7 - sd0 mask bit 0 gates current-limit flag
// R8 - bits 5 and 1 read-only, read zero
// R9 - lr1 mask bit 7 gates pg-invalid flag
// R10 - lr1 mask bit 6 gates pg-valid flag
// R11 - lr1 live power-good ignores every mask
// R12 - lr0 mask bit 3 gates pg-invalid flag
// R13 - lr0 mask bit 2 gates pg-valid flag
// R14 - lr0 mask bit 0 gates current-limit flag
// R15 - linear regulator mask register at 0x23
// R16 - lr1 mask bit 4 gates current-limit flag
// R17 - mask reset values loaded from OTP
// R18 - pg flag ORs both edges, sticky
`timescale 1ns/100ps
module regulator_irq_mask_gating
   import regulator_irq_mask_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // factory configuration
   input wire logic [7:0] otp_sd_mask_i,
   input wire logic [7:0] otp_lr_mask_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // analog monitor levels, asynchronous
   input wire logic [NUM_REG-1:0] pg_level_i,
   input wire logic [NUM_REG-1:0] curlim_level_i,
   // flag clears from the flag register logic
   input wire logic [NUM_REG-1:0] pg_irq_clr_i,
   input wire logic [NUM_REG-1:0] curlim_irq_clr_i,
   // flags and live status
   output logic [NUM_REG-1:0] pg_irq_o,
   output logic [NUM_REG-1:0] curlim_irq_o,
   output logic [NUM_REG-1:0] pg_live_o,
   output logic [NUM_REG-1:0] curlim_live_o,
   output logic ready_o
);

   logic [7:0] step_down_irq_mask_q, step_down_irq_mask_d;
   logic [7:0] linear_reg_irq_mask_q, linear_reg_irq_mask_d;
   logic [7:0] rdata_q, rdata_d;
   logic [1:0] arm_cnt_q, arm_cnt_d;
   logic loaded_q, loaded_d;
   logic armed_q, armed_d;
   logic [NUM_REG-1:0] pg_s1_q, pg_s2_q, pg_prev_q, pg_prev_d;
   logic [NUM_REG-1:0] cl_s1_q, cl_s2_q, cl_prev_q, cl_prev_d;
   logic [NUM_REG-1:0] pg_irq_q, pg_irq_d;
   logic [NUM_REG-1:0] curlim_irq_q, curlim_irq_d;

   // two-stage synchronisers; live status never sees the masks
   // the levels are asynchronous to clock_i and may change at any time
   // only the second stage reads the first, so no raw level leaks into logic
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pg_s1_q <= '0;
         pg_s2_q <= '0;
         cl_s1_q <= '0;
         cl_s2_q <= '0;
      end else begin
         pg_s1_q <= pg_level_i;
         pg_s2_q <= pg_s1_q; // R2 R11
         cl_s1_q <= curlim_level_i;
         cl_s2_q <= cl_s1_q; // R4
      end
   end

   // mask registers: otp load once after reset, then software writes
   // a write in the load cycle is dropped so the otp image always lands
   always_comb begin
      step_down_irq_mask_d = step_down_irq_mask_q;
      linear_reg_irq_mask_d = linear_reg_irq_mask_q;
      loaded_d = 1'b1;
      if (!loaded_q) begin
         step_down_irq_mask_d = otp_sd_mask_i & MASK_WR_BITS; // R17
         linear_reg_irq_mask_d = otp_lr_mask_i & MASK_WR_BITS; // R17
      end else if (reg_wr_i) begin
         if (reg_addr_i == ADDR_SD_MASK) begin
            step_down_irq_mask_d = reg_wdata_i & MASK_WR_BITS; // R8
         end
         if (reg_addr_i == ADDR_LR_MASK) begin // R15
            linear_reg_irq_mask_d = reg_wdata_i & MASK_WR_BITS; // R8
         end
      end
   end

   // mask state; reset clears it until the otp image is loaded
   // reserved bits never reach these flops, so they read zero
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         step_down_irq_mask_q <= REG_ZERO;
         linear_reg_irq_mask_q <= REG_ZERO;
         loaded_q <= 1'b0;
      end else begin
         step_down_irq_mask_q <= step_down_irq_mask_d;
         linear_reg_irq_mask_q <= linear_reg_irq_mask_d;
         loaded_q <= loaded_d; // R17
      end
   end

   // read data, unmapped addresses read zero
   // a read in the cycle of a write returns the value held before it
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_i) begin
         if (reg_addr_i == ADDR_SD_MASK) begin
            rdata_d = step_down_irq_mask_q;
         end else if (reg_addr_i == ADDR_LR_MASK) begin // R15
            rdata_d = linear_reg_irq_mask_q;
         end else begin
            rdata_d = REG_ZERO;
         end
      end
   end

   // read data register, held until the next read
   // software may poll it; it changes only on a read strobe
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= REG_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // arm the edge detectors once the synchronisers hold real levels
   // before that the cleared previous-level flops would fake an edge
   always_comb begin
      arm_cnt_d = arm_cnt_q;
      armed_d = armed_q;
      if (!armed_q) begin
         if (arm_cnt_q == ARM_WAIT) begin
            armed_d = 1'b1;
         end else begin
            arm_cnt_d = arm_cnt_q + ARM_ONE;
         end
      end
   end

   // arm counter state
   // the counter stops once armed and stays there until reset
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arm_cnt_q <= ARM_ZERO;
         armed_q <= 1'b0;
      end else begin
         arm_cnt_q <= arm_cnt_d;
         armed_q <= armed_d;
      end
   end

   // edge detection, mask gating and sticky flags; set beats clear
   // a masked edge is lost for good: clearing the mask later raises nothing
   // current-limit flags react to the rising detection only
   always_comb begin
      logic [7:0] mask_byte;
      int off;
      logic pg_rise, pg_fall, cl_rise, pg_set, cl_set;
      mask_byte = REG_ZERO;
      off = 0;
      pg_rise = 1'b0;
      pg_fall = 1'b0;
      cl_rise = 1'b0;
      pg_set = 1'b0;
      cl_set = 1'b0;
      pg_prev_d = pg_s2_q;
      cl_prev_d = cl_s2_q;
      pg_irq_d = pg_irq_q;
      curlim_irq_d = curlim_irq_q;
      // indices 0 and 1 use the step-down byte, 2 and 3 the linear byte; odd ones use the upper nibble
      for (int i = 0; i < NUM_REG; i++) begin
         mask_byte = (i < NUM_SD) ? step_down_irq_mask_q : linear_reg_irq_mask_q;
         off = (i % NUM_SD) * HALF_W;
         pg_rise = armed_q & pg_s2_q[i] & ~pg_prev_q[i];
         pg_fall = armed_q & ~pg_s2_q[i] & pg_prev_q[i];
         cl_rise = armed_q & cl_s2_q[i] & ~cl_prev_q[i];
         // valid edge gated by bit 2/6, invalid edge by bit 3/7
         pg_set = (pg_rise & ~mask_byte[off + PGR_POS]) // R1 R6 R10 R13
            | (pg_fall & ~mask_byte[off + PGF_POS]); // R5 R9 R12 R18
         cl_set = cl_rise & ~mask_byte[off + ILIM_POS]; // R3 R7 R14 R16
         pg_irq_d[i] = pg_set | (pg_irq_q[i] & ~pg_irq_clr_i[i]); // R18
         curlim_irq_d[i] = cl_set | (curlim_irq_q[i] & ~curlim_irq_clr_i[i]);
      end
   end

   // previous levels and flag state
   // flags clear only by reset or a clear pulse from the flag logic
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pg_prev_q <= '0;
         cl_prev_q <= '0;
         pg_irq_q <= '0;
         curlim_irq_q <= '0;
      end else begin
         pg_prev_q <= pg_prev_d;
         cl_prev_q <= cl_prev_d;
         pg_irq_q <= pg_irq_d;
         curlim_irq_q <= curlim_irq_d;
      end
   end

   // outputs straight from flops
   // live status comes straight from the second synchroniser stage
   // ready_o tells the flag register logic that edges now count as events
   assign reg_rdata_o = rdata_q;
   assign pg_irq_o = pg_irq_q;
   assign curlim_irq_o = curlim_irq_q;
   assign pg_live_o = pg_s2_q;
   assign curlim_live_o = cl_s2_q;
   assign ready_o = armed_q;

endmodule : regulator_irq_mask_gating

// >>> hdl/regulator_irq_mask_pkg.sv
package regulator_irq_mask_pkg;
   // register addresses on the serial register port
   localparam logic [7:0] ADDR_SD_MASK = 8'h22;
   localparam logic [7:0] ADDR_LR_MASK = 8'h23;
   // writable bits of both mask registers, bits 5 and 1 stay zero
   localparam logic [7:0] MASK_WR_BITS = 8'hDD;
   localparam logic [7:0] REG_ZERO = 8'h00;
   // field positions inside one regulator's half of a mask byte
   localparam int ILIM_POS = 0;
   localparam int PGR_POS = 2;
   localparam int PGF_POS = 3;
   localparam int HALF_W = 4;
   // regulator indices: 0 = sd0, 1 = sd1, 2 = lr0, 3 = lr1
   localparam int NUM_REG = 4;
   localparam int NUM_SD = 2;
   // arm counter value at which the edge detectors are armed, four cycles after reset release
   localparam logic [1:0] ARM_WAIT = 2'h3;
   localparam logic [1:0] ARM_ONE = 2'h1;
   localparam logic [1:0] ARM_ZERO = 2'h0;
endpackage : regulator_irq_mask_pkg

// >>> tb/regulator_irq_mask_gating_asserts.sv
`timescale 1ns/100ps
module regulator_irq_mask_gating_asserts
   import regulator_irq_mask_pkg::*;
(
   // clock, reset and register port
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // monitors, clears and flags
   input wire logic [NUM_REG-1:0] pg_level_i,
   input wire logic [NUM_REG-1:0] curlim_level_i,
   input wire logic [NUM_REG-1:0] pg_irq_clr_i,
   input wire logic [NUM_REG-1:0] curlim_irq_clr_i,
   input wire logic [NUM_REG-1:0] pg_irq_o,
   input wire logic [NUM_REG-1:0] curlim_irq_o,
   input wire logic [NUM_REG-1:0] pg_live_o,
   input wire logic [NUM_REG-1:0] curlim_live_o,
   input wire logic ready_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // read data, live status and flag relations
   chk_rsvd_read_zero: assert property (!reg_rdata_o[5] && !reg_rdata_o[1])
      else $error("reserved bit read as one");
   chk_unmapped_read_zero: assert property (
      reg_rd_i && reg_addr_i != ADDR_SD_MASK && reg_addr_i != ADDR_LR_MASK
      |=> reg_rdata_o == REG_ZERO)
      else $error("unmapped read not zero");
   chk_pg_live_follows: assert property (
      ready_o |-> pg_live_o == $past(pg_level_i, 2))
      else $error("live power-good wrong");
   chk_cl_live_follows: assert property (
      ready_o |-> curlim_live_o == $past(curlim_level_i, 2))
      else $error("live current-limit wrong");
   chk_pg_set_cause: assert property (
      (pg_irq_o & ~$past(pg_irq_o) & ~($past(pg_live_o) ^ $past(pg_live_o, 2))) == 4'h0)
      else $error("power-good flag set without edge");
   chk_cl_set_cause: assert property (
      (curlim_irq_o & ~$past(curlim_irq_o)
      & ~($past(curlim_live_o) & ~$past(curlim_live_o, 2))) == 4'h0)
      else $error("current-limit flag set without rise");
   chk_pg_flag_sticky: assert property (
      1'b1 |=> (($past(pg_irq_o) & ~$past(pg_irq_clr_i)) & ~pg_irq_o) == 4'h0)
      else $error("power-good flag dropped");
   chk_cl_flag_sticky: assert property (
      1'b1 |=> (($past(curlim_irq_o) & ~$past(curlim_irq_clr_i)) & ~curlim_irq_o) == 4'h0)
      else $error("current-limit flag dropped");
   // a full clear while the live levels hold still empties every flag
   sequence pg_clear_quiet;
      pg_irq_clr_i == 4'hF && pg_live_o == $past(pg_live_o);
   endsequence
   sequence cl_clear_quiet;
      curlim_irq_clr_i == 4'hF && curlim_live_o == $past(curlim_live_o);
   endsequence
   chk_pg_clear_all: assert property (pg_clear_quiet |=> pg_irq_o == 4'h0)
      else $error("power-good flag survived clear");
   chk_cl_clear_all: assert property (cl_clear_quiet |=> curlim_irq_o == 4'h0)
      else $error("current-limit flag survived clear");
endmodule : regulator_irq_mask_gating_asserts
bind regulator_irq_mask_gating regulator_irq_mask_gating_asserts chk (.*);

// >>> tb/test_regulator_irq_mask_gating.sv
`timescale 1ns/100ps
module test_regulator_irq_mask_gating;
   import regulator_irq_mask_pkg::*;
   logic clock_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, ready_o;
   logic [7:0] otp_sd_mask_i = 8'hFF, otp_lr_mask_i = 8'h5A, reg_addr_i = '0, reg_wdata_i = '0;
   logic [7:0] reg_rdata_o, a, e;
   logic [3:0] pg_level_i = '0, curlim_level_i = '0, pg_irq_clr_i = '0, curlim_irq_clr_i = '0;
   logic [3:0] pg_irq_o, curlim_irq_o, pg_live_o, curlim_live_o;
   int err_count = 0, check_count = 0, cyc = 0, b, i, f, m;
   always #5 clock_i = ~clock_i;
   regulator_irq_mask_gating DUT (.*);
   // verdict and end of run
   task stop_test;
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one register write or read on the strobe port
   task wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clock_i);
      reg_addr_i <= ad;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask : rd
   // hang guard
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      #1 chk({7'h00, ready_o}, 8'h01);
      rd(ADDR_SD_MASK, 8'hDD);
      rd(ADDR_LR_MASK, 8'h58);
      wr(ADDR_LR_MASK, 8'hFF);
      rd(ADDR_LR_MASK, 8'hDD);
      rd(8'h24, 8'h00);
      // every regulator, event and mask value
      for (int k = 0; k < 24; k++) begin
         i = k / 6;
         f = k / 2 % 3;
         m = k % 2;
         b = (f == 0 ? 0 : f + 1) + 4 * (i % 2);
         a = i < 2 ? ADDR_SD_MASK : ADDR_LR_MASK;
         wr(ADDR_SD_MASK, 8'hFF);
         wr(ADDR_LR_MASK, 8'hFF);
         pg_level_i[i] <= f == 2;
         curlim_level_i[i] <= 1'b0;
         repeat (5) @(posedge clock_i);
         wr(a, m ? 8'hFF : ~(8'h01 << b));
         if (f == 0) curlim_level_i[i] <= 1'b1;
         else pg_level_i[i] <= f == 1;
         e = m ? 8'h00 : 8'(f ? 16 << i : 1 << i);
         repeat (5) @(posedge clock_i);
         #1 chk({pg_irq_o, curlim_irq_o}, e);
         chk({pg_live_o, curlim_live_o}, {pg_level_i, curlim_level_i});
         @(posedge clock_i);
         pg_irq_clr_i <= 4'hF;
         curlim_irq_clr_i <= 4'hF;
         @(posedge clock_i);
         pg_irq_clr_i <= 4'h0;
         curlim_irq_clr_i <= 4'h0;
         @(posedge clock_i);
         #1 chk({pg_irq_o, curlim_irq_o}, 8'h00);
      end
      stop_test();
   end
endmodule : test_regulator_irq_mask_gating
